// ---- hw/emseq_pkg.sv ----
// constants and types of the extended-mode bus-cycle sequencer
package emseq_pkg;

	// ---------------------------------------------------------------
	// widths, fixed values and reset values
	// ---------------------------------------------------------------
	localparam int          ADDR_W      = 16;
	localparam int          DATA_W      = 8;
	localparam int          STEP_W      = 3;
	localparam logic [15:0] DUMMY_ADDR  = 16'hFFFF;
	localparam logic [7:0]  CLEAR_DATA  = 8'h00;
	localparam logic [15:0] FETCH_SKIP  = 16'h0003;   // opcode plus two address bytes
	localparam logic [15:0] RST_ADDR    = 16'h0000;
	localparam logic [7:0]  RST_DATA    = 8'h00;
	localparam logic        BUS_READ    = 1'b1;
	localparam logic        BUS_WRITE   = 1'b0;

	// ---------------------------------------------------------------
	// cycle counts per instruction group
	// ---------------------------------------------------------------
	localparam logic [2:0]  CYC_JUMP    = 3'h3;
	localparam logic [2:0]  CYC_READ8   = 3'h4;
	localparam logic [2:0]  CYC_STORE8  = 3'h4;
	localparam logic [2:0]  CYC_LOAD16  = 3'h5;
	localparam logic [2:0]  CYC_STORE16 = 3'h5;
	localparam logic [2:0]  CYC_CLEAR   = 3'h5;
	localparam logic [2:0]  CYC_CALL    = 3'h6;
	localparam logic [2:0]  CYC_RMW     = 3'h6;

	// ---------------------------------------------------------------
	// enumerations
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		GRP_JUMP    = 3'h0,
		GRP_CALL    = 3'h1,
		GRP_READ8   = 3'h2,
		GRP_STORE8  = 3'h3,
		GRP_LOAD16  = 3'h4,
		GRP_STORE16 = 3'h5,
		GRP_RMW     = 3'h6,
		GRP_CLEAR   = 3'h7
	} emseq_group_t;

	typedef enum logic [2:0] {
		AS_OPC1  = 3'h0,
		AS_OPC2  = 3'h1,
		AS_NEXT  = 3'h2,
		AS_EA    = 3'h3,
		AS_EA1   = 3'h4,
		AS_DUMMY = 3'h5,
		AS_SP    = 3'h6,
		AS_SPM1  = 3'h7
	} emseq_addr_t;

	typedef enum logic [2:0] {
		DS_NONE  = 3'h0,
		DS_ACC   = 3'h1,
		DS_REGHI = 3'h2,
		DS_REGLO = 3'h3,
		DS_RETLO = 3'h4,
		DS_RETHI = 3'h5,
		DS_MOD   = 3'h6,
		DS_ZERO  = 3'h7
	} emseq_data_t;

	typedef enum logic [2:0] {
		CAP_NONE = 3'h0,
		CAP_EAHI = 3'h1,
		CAP_EALO = 3'h2,
		CAP_OPHI = 3'h3,
		CAP_OPLO = 3'h4
	} emseq_cap_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} emseq_state_t;

endpackage

// ---- hw/emseq_step_rom.sv ----
// per-group, per-cycle bus step table of the sequencer
`timescale 1ns/1ps
module emseq_step_rom
	import emseq_pkg::*;
(
	input  wire emseq_pkg::emseq_group_t group,
	input  wire logic [emseq_pkg::STEP_W-1:0] step,
	output emseq_pkg::emseq_addr_t addrSel,
	output logic                   rwRead,
	output emseq_pkg::emseq_data_t dataSel,
	output emseq_pkg::emseq_cap_t  capSel,
	output logic                   last
);
	// ---------------------------------------------------------------
	// cycle count of a group
	// ---------------------------------------------------------------
	function automatic logic [2:0] cyclesOf(input emseq_group_t g);
		case (g)
			GRP_JUMP:    cyclesOf = CYC_JUMP;
			GRP_CALL:    cyclesOf = CYC_CALL;
			GRP_READ8:   cyclesOf = CYC_READ8;
			GRP_STORE8:  cyclesOf = CYC_STORE8;
			GRP_LOAD16:  cyclesOf = CYC_LOAD16;
			GRP_STORE16: cyclesOf = CYC_STORE16;
			GRP_RMW:     cyclesOf = CYC_RMW;
			default:     cyclesOf = CYC_CLEAR;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// step decode
	// ---------------------------------------------------------------
	// every group opens with the two address bytes after the opcode
	always_comb
	begin
		addrSel = AS_NEXT;
		rwRead  = BUS_READ;
		dataSel = DS_NONE;
		capSel  = CAP_NONE;
		last    = (step == cyclesOf(group));
		if (step == 3'h1)
		begin
			addrSel = AS_OPC1;
			capSel  = CAP_EAHI;
		end
		else if (step == 3'h2)
		begin
			addrSel = AS_OPC2;
			capSel  = CAP_EALO;
		end
		else if (!last)
		begin
			case (group)
				GRP_READ8:
				begin
					addrSel = AS_EA;
					capSel  = CAP_OPLO;
				end
				GRP_LOAD16:
				begin
					addrSel = (step == 3'h3) ? AS_EA : AS_EA1;
					capSel  = (step == 3'h3) ? CAP_OPHI : CAP_OPLO;
				end
				GRP_STORE8:
				begin
					addrSel = AS_EA;
					rwRead  = BUS_WRITE;
					dataSel = DS_ACC;
				end
				GRP_STORE16:
				begin
					addrSel = (step == 3'h3) ? AS_EA : AS_EA1;
					rwRead  = BUS_WRITE;
					dataSel = (step == 3'h3) ? DS_REGHI : DS_REGLO;
				end
				GRP_CALL:
				begin
					addrSel = (step == 3'h3) ? AS_DUMMY : ((step == 3'h4) ? AS_SP : AS_SPM1);
					rwRead  = (step == 3'h3) ? BUS_READ : BUS_WRITE;
					dataSel = (step == 3'h3) ? DS_NONE : ((step == 3'h4) ? DS_RETLO : DS_RETHI);
				end
				GRP_RMW:
				begin
					addrSel = (step == 3'h4) ? AS_DUMMY : AS_EA;
					rwRead  = (step == 3'h5) ? BUS_WRITE : BUS_READ;
					dataSel = (step == 3'h5) ? DS_MOD : DS_NONE;
					capSel  = (step == 3'h3) ? CAP_OPLO : CAP_NONE;
				end
				GRP_CLEAR:
				begin
					addrSel = AS_EA;
					rwRead  = (step == 3'h4) ? BUS_WRITE : BUS_READ;
					dataSel = (step == 3'h4) ? DS_ZERO : DS_NONE;
					capSel  = (step == 3'h3) ? CAP_OPLO : CAP_NONE;
				end
				default:
				begin
					addrSel = AS_NEXT;
				end
			endcase
		end
		// jump and call end at the target
		else if (group == GRP_JUMP || group == GRP_CALL)
		begin
			addrSel = AS_EA;
		end
	end

endmodule // emseq_step_rom

// ---- hw/emseq_sequencer.sv ----
// extended-mode bus-cycle sequencer: drives address, read/write and data per cycle
`timescale 1ns/1ps
module emseq_sequencer
	import emseq_pkg::*;
#(
	parameter int ADDR_WIDTH = emseq_pkg::ADDR_W,
	parameter int DATA_WIDTH = emseq_pkg::DATA_W
)
(
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 start,
	input  wire emseq_pkg::emseq_group_t group,
	input  wire logic [15:0]          opAddr,
	input  wire logic [15:0]          regData,
	input  wire logic [15:0]          stackPtr,
	input  wire logic [7:0]           modData,
	input  wire logic [7:0]           busRdData,
	output logic [15:0]               busAddr_r,
	output logic                      busRead_r,
	output logic [7:0]                busWrData_r,
	output logic                      busValid_r,
	output logic                      done_r,
	output logic                      ready_r,
	output logic [15:0]               operand_r,
	output logic [15:0]               target_r
);
	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	// the bus step table only knows a 16-bit address and byte data
	if (ADDR_WIDTH != 16 || DATA_WIDTH != 8)
	begin : g_badWidth
		$error("emseq_sequencer supports only 16-bit address and 8-bit data");
	end

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	emseq_state_t             state_r,    state_nxt;
	logic [STEP_W-1:0]        step_r,     step_nxt;
	emseq_group_t             group_r,    group_nxt;
	logic [15:0]              opAddr_r,   opAddr_nxt;
	logic [15:0]              regData_r,  regData_nxt;
	logic [15:0]              stackPtr_r, stackPtr_nxt;
	logic [7:0]               eaHi_r,     eaHi_nxt;
	emseq_cap_t               cap_r,      cap_nxt;
	logic                     last_r,     last_nxt;
	logic [15:0]              busAddr_nxt;
	logic                     busRead_nxt;
	logic [7:0]               busWrData_nxt;
	logic                     busValid_nxt;
	logic                     done_nxt;
	logic                     ready_nxt;
	logic [15:0]              operand_nxt;
	logic [15:0]              target_nxt;

	// ---------------------------------------------------------------
	// step table lookup for the cycle about to be driven
	// ---------------------------------------------------------------
	emseq_group_t             romGroup;
	logic [STEP_W-1:0]        romStep;
	emseq_addr_t              romAddr;
	logic                     romRead;
	emseq_data_t              romData;
	emseq_cap_t               romCap;
	logic                     romLast;
	logic                     take;
	logic [15:0]              eaNow;
	logic [15:0]              retAddr;

	// a new instruction may be taken while idle or in the final fetch cycle
	assign take     = start && (state_r == ST_IDLE || last_r);
	assign romGroup = take ? group : group_r;
	assign romStep  = take ? 3'h1 : 3'(step_r + 3'h1);
	// the low address byte arrives on the bus during step 2; use it at once
	assign eaNow    = (cap_r == CAP_EALO) ? {eaHi_r, busRdData} : target_r;
	assign retAddr  = 16'(opAddr_r + FETCH_SKIP);

	emseq_step_rom u_rom
	(
		.group   (romGroup),
		.step    (romStep),
		.addrSel (romAddr),
		.rwRead  (romRead),
		.dataSel (romData),
		.capSel  (romCap),
		.last    (romLast)
	);

	// ---------------------------------------------------------------
	// address and data selection
	// ---------------------------------------------------------------
	function automatic logic [15:0] addrOf(input emseq_addr_t s, input logic [15:0] opc,
		input logic [15:0] ea, input logic [15:0] sp);
		case (s)
			AS_OPC1:  addrOf = 16'(opc + 16'h0001);
			AS_OPC2:  addrOf = 16'(opc + 16'h0002);
			AS_NEXT:  addrOf = 16'(opc + FETCH_SKIP);
			AS_EA:    addrOf = ea;
			AS_EA1:   addrOf = 16'(ea + 16'h0001);
			AS_DUMMY: addrOf = DUMMY_ADDR;
			AS_SP:    addrOf = sp;
			AS_SPM1:  addrOf = 16'(sp - 16'h0001);
			default:  addrOf = DUMMY_ADDR;
		endcase
	endfunction

	// write data chosen per step; read steps leave the data lines at zero
	function automatic logic [7:0] dataOf(input emseq_data_t s, input logic [15:0] reg16,
		input logic [15:0] ret, input logic [7:0] md);
		case (s)
			DS_ACC:   dataOf = reg16[7:0];
			DS_REGHI: dataOf = reg16[15:8];
			DS_REGLO: dataOf = reg16[7:0];
			DS_RETLO: dataOf = ret[7:0];
			DS_RETHI: dataOf = ret[15:8];
			DS_MOD:   dataOf = md;
			DS_ZERO:  dataOf = CLEAR_DATA;
			default:  dataOf = RST_DATA;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	// captures act on the step now on the bus, the table on the step to come
	always_comb
	begin
		state_nxt     = state_r;
		step_nxt      = step_r;
		group_nxt     = group_r;
		opAddr_nxt    = opAddr_r;
		regData_nxt   = regData_r;
		stackPtr_nxt  = stackPtr_r;
		eaHi_nxt      = eaHi_r;
		cap_nxt       = CAP_NONE;
		last_nxt      = 1'b0;
		busAddr_nxt   = busAddr_r;
		busRead_nxt   = BUS_READ;
		busWrData_nxt = RST_DATA;
		busValid_nxt  = 1'b0;
		done_nxt      = 1'b0;
		operand_nxt   = operand_r;
		target_nxt    = target_r;

		// bytes fetched after the opcode form the address
		if (state_r == ST_RUN)
		begin
			case (cap_r)
				CAP_EAHI: eaHi_nxt = busRdData;
				CAP_EALO: target_nxt = eaNow;
				CAP_OPHI: operand_nxt = {busRdData, operand_r[7:0]};
				CAP_OPLO: operand_nxt = {operand_r[15:8], busRdData};
				default:  eaHi_nxt = eaHi_r;
			endcase
		end

		if (take)
		begin
			// group, opAddr, regData and stackPtr are held for the whole instruction; modData is used live
			state_nxt    = ST_RUN;
			group_nxt    = group;
			opAddr_nxt   = opAddr;
			regData_nxt  = regData;
			stackPtr_nxt = stackPtr;
			step_nxt     = 3'h1;
			operand_nxt  = 16'h0000;
			busAddr_nxt  = addrOf(romAddr, opAddr, target_r, stackPtr);
			busRead_nxt  = romRead;
			busWrData_nxt = dataOf(romData, regData, 16'(opAddr + FETCH_SKIP), modData);
			busValid_nxt = 1'b1;
			cap_nxt      = romCap;
			last_nxt     = romLast;
			done_nxt     = romLast;
		end
		else if (state_r == ST_RUN && !last_r)
		begin
			// dummy and write steps come from the table
			step_nxt      = romStep;
			busAddr_nxt   = addrOf(romAddr, opAddr_r, eaNow, stackPtr_r);
			busRead_nxt   = romRead;
			busWrData_nxt = dataOf(romData, regData_r, retAddr, modData);
			busValid_nxt  = 1'b1;
			cap_nxt       = romCap;
			last_nxt      = romLast;
			done_nxt      = romLast;
		end
		else if (state_r == ST_RUN)
		begin
			// fetch cycle ended with nothing new to start
			state_nxt = ST_IDLE;
			step_nxt  = 3'h0;
		end

		// ready when the cycle after this one may take a new instruction
		ready_nxt = (state_nxt == ST_IDLE) || last_nxt;
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state_r     <= ST_IDLE;
			step_r      <= 3'h0;
			group_r     <= GRP_JUMP;
			opAddr_r    <= RST_ADDR;
			regData_r   <= RST_ADDR;
			stackPtr_r  <= RST_ADDR;
			eaHi_r      <= RST_DATA;
			cap_r       <= CAP_NONE;
			last_r      <= 1'b0;
			busAddr_r   <= RST_ADDR;
			busRead_r   <= BUS_READ;
			busWrData_r <= RST_DATA;
			busValid_r  <= 1'b0;
			done_r      <= 1'b0;
			ready_r     <= 1'b1;
			operand_r   <= RST_ADDR;
			target_r    <= RST_ADDR;
		end
		else
		begin
			state_r     <= state_nxt;
			step_r      <= step_nxt;
			group_r     <= group_nxt;
			opAddr_r    <= opAddr_nxt;
			regData_r   <= regData_nxt;
			stackPtr_r  <= stackPtr_nxt;
			eaHi_r      <= eaHi_nxt;
			cap_r       <= cap_nxt;
			last_r      <= last_nxt;
			busAddr_r   <= busAddr_nxt;
			busRead_r   <= busRead_nxt;
			busWrData_r <= busWrData_nxt;
			busValid_r  <= busValid_nxt;
			done_r      <= done_nxt;
			ready_r     <= ready_nxt;
			operand_r   <= operand_nxt;
			target_r    <= target_nxt;
		end
	end

endmodule // emseq_sequencer

// ---- test/emseq_sequencer_assertions.sv ----
// concurrent checks on the ports of the extended-mode bus-cycle sequencer
`timescale 1ns/1ps
module emseq_sequencer_sva
	import emseq_pkg::*;
(
	input wire logic                    core_clk,
	input wire logic                    sys_rst,
	input wire logic                    start,
	input wire emseq_pkg::emseq_group_t group,
	input wire logic [15:0]             opAddr,
	input wire logic [15:0]             regData,
	input wire logic [15:0]             stackPtr,
	input wire logic [7:0]              modData,
	input wire logic [7:0]              busRdData,
	input wire logic [15:0]             busAddr_r,
	input wire logic                    busRead_r,
	input wire logic [7:0]              busWrData_r,
	input wire logic                    done_r,
	input wire logic                    ready_r,
	input wire logic [15:0]             operand_r,
	input wire logic [15:0]             target_r
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// an instruction is taken only while the sequencer says it is ready
	wire tk = start && ready_r;
	// ----------------------------------------
	// walks; $past of opAddr, regData and stackPtr at depth k reaches the take edge
	// ----------------------------------------
	a_jump_walk:
	assert property (tk && group == GRP_JUMP |=> busAddr_r == $past(opAddr) + 16'h0001
		##1 busAddr_r == $past(opAddr, 2) + 16'h0002
		##1 done_r && busRead_r && busAddr_r == target_r) else $error("jump walk wrong");
	a_read8_walk:
	assert property (tk && group == GRP_READ8 |=> ##2 busRead_r && busAddr_r == target_r
		&& !done_r ##1 done_r && busAddr_r == $past(opAddr, 4) + 16'h0003)
		else $error("8-bit read walk wrong");
	a_store8_write:
	assert property (tk && group == GRP_STORE8 |=> ##2 !busRead_r && busAddr_r == target_r
		&& busWrData_r == 8'($past(regData, 3)) ##1 busRead_r && done_r)
		else $error("accumulator store wrong");
	a_store16_pair:
	assert property (tk && group == GRP_STORE16 |=> ##2 !busRead_r && busAddr_r == target_r
		&& busWrData_r == 8'($past(regData, 3) >> 8) ##1 !busRead_r
		&& busAddr_r == target_r + 16'h0001 && busWrData_r == 8'($past(regData, 4))
		##1 busRead_r && done_r) else $error("16-bit store wrong");
	a_load16_pair:
	assert property (tk && group == GRP_LOAD16 |=> ##2 busRead_r && busAddr_r == target_r
		##1 busRead_r && busAddr_r == target_r + 16'h0001
		##1 done_r && operand_r == {$past(busRdData, 2), $past(busRdData)})
		else $error("16-bit load wrong");
	a_call_push:
	assert property (tk && group == GRP_CALL |=> ##2 busRead_r && busAddr_r == 16'hFFFF
		##1 !busRead_r && busAddr_r == $past(stackPtr, 4)
		&& busWrData_r == 8'($past(opAddr, 4) + 16'h0003)
		##1 !busRead_r && busAddr_r == $past(stackPtr, 5) - 16'h0001
		&& busWrData_r == 8'(($past(opAddr, 5) + 16'h0003) >> 8)
		##1 done_r && busAddr_r == target_r) else $error("call walk wrong");
	a_rmw_walk:
	assert property (tk && group == GRP_RMW |=> ##2 busRead_r && busAddr_r == target_r
		##1 busRead_r && busAddr_r == 16'hFFFF ##1 !busRead_r && busAddr_r == target_r
		&& busWrData_r == $past(modData) ##1 done_r) else $error("modify walk wrong");
	a_clear_zero:
	assert property (tk && group == GRP_CLEAR |=> ##2 busRead_r && busAddr_r == target_r
		##1 !busRead_r && busAddr_r == target_r && busWrData_r == 8'h00
		##1 done_r && busAddr_r == $past(opAddr, 5) + 16'h0003)
		else $error("clear walk wrong");
	a_done_pulse:
	assert property (done_r |=> !done_r) else $error("done longer than one cycle");
	// main scenarios reached
	c_call: cover property (tk && group == GRP_CALL);
	c_chain: cover property (done_r && start);
	c_rmw: cover property (tk && group == GRP_RMW);
endmodule // emseq_sequencer_sva

bind emseq_sequencer emseq_sequencer_sva u_sva (.core_clk(core_clk), .sys_rst(sys_rst),
	.start(start), .group(group), .opAddr(opAddr), .regData(regData),
	.stackPtr(stackPtr), .modData(modData), .busRdData(busRdData),
	.busAddr_r(busAddr_r), .busRead_r(busRead_r), .busWrData_r(busWrData_r),
	.done_r(done_r), .ready_r(ready_r), .operand_r(operand_r), .target_r(target_r));

// ---- test/emseq_mem_model.sv ----
// memory on the far side of the sequencer's bus
`timescale 1ns/1ps
module emseq_mem_model
(
	input  wire logic        core_clk,
	input  wire logic [15:0] busAddr_r,
	input  wire logic        busRead_r,
	input  wire logic [7:0]  busWrData_r,
	input  wire logic        busValid_r,
	output logic [7:0]       busRdData
);
	logic [7:0] mem [0:65535];
	logic [7:0] lastRd;
	// address pattern fill: each location holds its high address byte XOR its low byte XOR A5
	initial
	begin
		lastRd = 8'h00;
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'(i[15:8] ^ i[7:0] ^ 8'hA5);
	end
	// outside a read the bus shows a changing inverse, so stale data never matches
	assign busRdData = (busValid_r && busRead_r) ? mem[busAddr_r] : ~lastRd;
	// a write lands at the edge that ends its cycle
	always @(posedge core_clk)
	begin
		lastRd <= busRdData;
		if (busValid_r && !busRead_r)
			mem[busAddr_r] <= busWrData_r;
	end
endmodule // emseq_mem_model

// ---- test/emseq_sequencer_tb_top.sv ----
// self-checking bench of the extended-mode bus-cycle sequencer
`timescale 1ns/1ps
module emseq_sequencer_tb_top;
	import emseq_pkg::*;
	logic core_clk = 1'b0, sys_rst = 1'b1, start = 1'b0;
	emseq_group_t group = GRP_JUMP;
	logic [15:0] opAddr = 16'h0000, regData = 16'h0000, stackPtr = 16'h0000;
	logic [7:0] modData = 8'h00, busRdData, busWrData_r;
	logic [15:0] busAddr_r, operand_r, target_r;
	logic busRead_r, busValid_r, done_r, ready_r;
	logic [26:0] xq[$], tq[$];
	int mismatches = 0, check_count = 0;
	emseq_sequencer DUT (.core_clk(core_clk), .sys_rst(sys_rst), .start(start),
		.group(group), .opAddr(opAddr), .regData(regData), .stackPtr(stackPtr),
		.modData(modData), .busRdData(busRdData), .busAddr_r(busAddr_r),
		.busRead_r(busRead_r), .busWrData_r(busWrData_r), .busValid_r(busValid_r),
		.done_r(done_r), .ready_r(ready_r), .operand_r(operand_r), .target_r(target_r));
	emseq_mem_model u_mem (.core_clk(core_clk), .busAddr_r(busAddr_r),
		.busRead_r(busRead_r), .busWrData_r(busWrData_r), .busValid_r(busValid_r),
		.busRdData(busRdData));
	// 100 MHz clock
	always #5 core_clk = ~core_clk;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[15:8] ^ a[7:0] ^ 8'hA5;
	endfunction
	// extended address held in the two bytes after the opcode
	function automatic logic [15:0] ea(input logic [15:0] a);
		return {pat(a + 16'h0001), pat(a + 16'h0002)};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic r(input logic [15:0] a, input logic n = 1'b0);
		xq.push_back({1'b1, n, 1'b1, a, 8'h00});
	endtask
	task automatic w(input logic [15:0] a, input logic [7:0] d);
		xq.push_back({3'b100, a, d});
	endtask
	task automatic hd(input logic [15:0] a);
		r(a + 16'h0001);
		r(a + 16'h0002);
	endtask
	// one bus cycle per entry, sampled 1 ns after each edge
	task automatic capture(input int n);
		repeat (n)
		begin
			tq.push_back({busValid_r, done_r, busRead_r, busAddr_r, busWrData_r});
			@(posedge core_clk);
			#1;
		end
	endtask
	task automatic go(input emseq_group_t g, input logic [15:0] a, input int n);
		start = 1'b1;
		group = g;
		opAddr = a;
		@(posedge core_clk);
		#1;
		start = 1'b0;
		capture(n);
	endtask
	// trace against expectation, then the sequencer must be idle and ready
	task automatic verify();
		foreach (xq[i]) chk(tq[i], xq[i]);
		chk(tq.size(), xq.size());
		chk({busValid_r, ready_r, done_r}, 3'b010);
		xq.delete();
		tq.delete();
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// jump, late start refused
	task automatic t_jump();
		start = 1'b1;
		opAddr = 16'h1000;
		@(posedge core_clk);
		#1;
		group = GRP_CLEAR;
		opAddr = 16'h7000;
		capture(1);
		start = 1'b0;
		capture(2);
		hd(16'h1000);
		r(ea(16'h1000), 1'b1);
		verify();
		chk(target_r, ea(16'h1000));
	endtask
	task automatic t_read8();
		go(GRP_READ8, 16'h2000, 4);
		hd(16'h2000);
		r(ea(16'h2000));
		r(16'h2003, 1'b1);
		verify();
		chk(operand_r, {8'h00, pat(ea(16'h2000))});
	endtask
	task automatic t_store8();
		regData = 16'h5AC3;
		go(GRP_STORE8, 16'h3000, 4);
		hd(16'h3000);
		w(ea(16'h3000), 8'hC3);
		r(16'h3003, 1'b1);
		verify();
	endtask
	// 16-bit load chained to 16-bit store
	task automatic t_chain();
		start = 1'b1;
		group = GRP_LOAD16;
		opAddr = 16'h4000;
		@(posedge core_clk);
		#1;
		group = GRP_STORE16;
		opAddr = 16'h5000;
		regData = 16'hBEEF;
		capture(4);
		chk(operand_r, {pat(ea(16'h4000)), pat(ea(16'h4000) + 16'h0001)});
		capture(1);
		start = 1'b0;
		capture(5);
		hd(16'h4000);
		r(ea(16'h4000));
		r(ea(16'h4000) + 16'h0001);
		r(16'h4003, 1'b1);
		hd(16'h5000);
		w(ea(16'h5000), 8'hBE);
		w(ea(16'h5000) + 16'h0001, 8'hEF);
		r(16'h5003, 1'b1);
		verify();
	endtask
	task automatic t_call();
		stackPtr = 16'h01FF;
		go(GRP_CALL, 16'h12F0, 6);
		hd(16'h12F0);
		r(16'hFFFF);
		w(16'h01FF, 8'hF3);
		w(16'h01FE, 8'h12);
		r(ea(16'h12F0), 1'b1);
		verify();
	endtask
	task automatic t_rmw();
		modData = 8'h3C;
		go(GRP_RMW, 16'h6000, 6);
		hd(16'h6000);
		r(ea(16'h6000));
		r(16'hFFFF);
		w(ea(16'h6000), 8'h3C);
		r(16'h6003, 1'b1);
		verify();
	endtask
	// clear, fetch addresses wrap past the top
	task automatic t_clear();
		go(GRP_CLEAR, 16'hFFFE, 5);
		hd(16'hFFFE);
		r(16'hA5A5);
		w(16'hA5A5, 8'h00);
		r(16'h0001, 1'b1);
		verify();
	endtask
	// reset in mid-call abandons it, then a jump starts clean
	task automatic t_reset();
		go(GRP_CALL, 16'h0800, 3);
		sys_rst = 1'b1;
		@(posedge core_clk);
		#1;
		sys_rst = 1'b0;
		hd(16'h0800);
		r(16'hFFFF);
		verify();
		chk({busAddr_r, busWrData_r, busValid_r, done_r, ready_r, busRead_r}, 32'h0000_0003);
		chk({operand_r, target_r}, 32'h0000_0000);
		go(GRP_JUMP, 16'h0900, 3);
		hd(16'h0900);
		r(ea(16'h0900), 1'b1);
		verify();
	endtask
	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// main sequence: reset for three cycles, then every scenario
	initial
	begin
		repeat (3) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
		chk({busAddr_r, busWrData_r, busValid_r, done_r, ready_r, busRead_r}, 32'h0000_0003);
		chk({operand_r, target_r}, 32'h0000_0000);
		t_jump();
		t_read8();
		t_store8();
		t_chain();
		t_call();
		t_rmw();
		t_clear();
		t_reset();
		end_sim();
	end
	// watchdog: the whole run needs well under a hundred cycles
	initial
	begin
		#20000;
		mismatches++;
		end_sim();
	end
endmodule // emseq_sequencer_tb_top
